/* File: logic/add_skip_map.vh */
`ifndef ADD_SKIP_MAP_VH
`define ADD_SKIP_MAP_VH
// opcodes
`define OP_ADD_NIB_HI     4'ha
`define OP_ADD_BYTE       8'hc9
`define OP_ADD_IND        8'h3f
`define OP_ADC_IND        8'h3e
`define OP_PAIR_PREFIX    8'hdc
`define OP_PAIR_SRC_HI    5'h13
`define OP_PAIR_DST_HI    5'h12
// pair selector field of second byte
`define PAIR_SEL_HI       2
`define PAIR_SEL_LO       1
// cycle counts
`define CYC_ONE_BYTE      2'h1
`define CYC_TWO_BYTE      2'h2
`endif

/* File: logic/add_skip_overflow_exec.v */
`timescale 1ns/1ps
`include "add_skip_map.vh"

module add_skip_overflow_exec (
  input  wire       mclk_i,
  input  wire       reset_n_i,
  input  wire       instr_valid_i,
  input  wire [7:0] byte0_i,
  input  wire [7:0] byte1_i,
  input  wire [3:0] mem_nibble_i,
  input  wire [7:0] pair_rd_data_i,
  output wire       busy_o,
  output reg  [1:0] pair_sel_o,
  output reg        pair_we_o,
  output reg  [7:0] pair_wr_data_o,
  output wire [3:0] work_nibble_o,
  output wire [7:0] extended_accumulator_o,
  output wire       carry_o,
  output reg        skip_o,
  output reg        done_o
);

  //////////////////////////////////////////////////////////////////////////
  // architectural state

  // work nibble is the low nibble of the extended accumulator
  reg  [7:0] ea_ff;
  reg        carry_ff;
  // a skip is owed to the next issued instruction
  reg        skip_pend_ff;
  // last executed instruction was the indirect add-with-carry
  reg        adc_prev_ff;
  // and that add-with-carry overflowed
  reg        adc_ovf_ff;
  // extra cycles still owed by the current instruction
  reg  [1:0] cnt_ff;

  //////////////////////////////////////////////////////////////////////////
  // next-state values and scratch

  reg  [7:0] nxt_ea;
  reg        nxt_carry;
  reg        nxt_skip_pend;
  reg        nxt_adc_ovf;
  reg        nxt_adc_prev;
  reg  [1:0] nxt_cnt;
  reg        nxt_skip;
  reg        nxt_done;
  reg  [8:0] sum9;
  reg  [4:0] sum5;
  reg  [1:0] len;
  reg        ovf;

  //////////////////////////////////////////////////////////////////////////
  // decoders

  // instruction length in bytes
  function [1:0] instr_len;
    input [7:0] b0;
    begin
      if (b0 == `OP_ADD_BYTE || b0 == `OP_PAIR_PREFIX)
        instr_len = `CYC_TWO_BYTE;
      else
        instr_len = `CYC_ONE_BYTE;
    end
  endfunction

  // literal nibble add form
  function is_nib_add;
    input [7:0] b0;
    begin
      is_nib_add = (b0[7:4] == `OP_ADD_NIB_HI);
    end
  endfunction

  // prefixed pair form with the given second-byte head
  function is_pair_form;
    input [7:0] b0;
    input [7:0] b1;
    input [4:0] hi;
    begin
      is_pair_form = (b0 == `OP_PAIR_PREFIX) &&
                     (b1[7:3] == hi) &&
                     !b1[0];
    end
  endfunction

  wire       issue;
  wire       nib_op;
  wire       src_op;
  wire       dst_op;
  wire       adc_squash;

  assign issue      = instr_valid_i && (cnt_ff == 2'h0);
  assign nib_op     = is_nib_add(byte0_i);
  assign src_op     = is_pair_form(byte0_i, byte1_i, `OP_PAIR_SRC_HI);
  assign dst_op     = is_pair_form(byte0_i, byte1_i, `OP_PAIR_DST_HI);
  // overflowing add-with-carry squashes a following nibble add
  assign adc_squash = adc_prev_ff && adc_ovf_ff && nib_op;

  //////////////////////////////////////////////////////////////////////////
  // outputs

  assign work_nibble_o          = ea_ff[3:0];
  assign extended_accumulator_o = ea_ff;
  assign carry_o                = carry_ff;
  assign busy_o                 = (cnt_ff != 2'h0);

  //////////////////////////////////////////////////////////////////////////
  // execute

  always @* begin
    nxt_ea         = ea_ff;
    nxt_carry      = carry_ff;
    nxt_skip_pend  = skip_pend_ff;
    nxt_adc_ovf    = adc_ovf_ff;
    nxt_adc_prev   = adc_prev_ff;
    nxt_cnt        = cnt_ff;
    nxt_skip       = 1'b0;
    nxt_done       = 1'b0;
    sum9           = 9'h000;
    sum5           = 5'h00;
    ovf            = 1'b0;
    len            = instr_len(byte0_i);
    pair_sel_o     = byte1_i[`PAIR_SEL_HI:`PAIR_SEL_LO];
    pair_we_o      = 1'b0;
    pair_wr_data_o = 8'h00;
    if (cnt_ff != 2'h0) begin
      // second byte time, requests ignored
      nxt_cnt = cnt_ff - 2'h1;
    end else if (issue) begin
      nxt_cnt  = len - 2'h1;
      nxt_done = 1'b1;
      if (skip_pend_ff) begin
        // squashed: no state but the bookkeeping moves
        nxt_skip      = 1'b1;
        nxt_skip_pend = 1'b0;
        nxt_adc_prev  = 1'b0;
        nxt_adc_ovf   = 1'b0;
      end else if (adc_squash) begin
        // squashed nibble add never owes a skip itself
        nxt_skip      = 1'b1;
        nxt_adc_prev  = 1'b0;
        nxt_adc_ovf   = 1'b0;
      end else begin
        nxt_adc_prev = 1'b0;
        nxt_adc_ovf  = 1'b0;
        if (nib_op) begin
          sum5 = {1'b0, ea_ff[3:0]} + {1'b0, byte0_i[3:0]};
          nxt_ea[3:0] = sum5[3:0];
          ovf = sum5[4] & ~adc_prev_ff;
        end else if (byte0_i == `OP_ADD_IND) begin
          sum5 = {1'b0, ea_ff[3:0]} + {1'b0, mem_nibble_i};
          nxt_ea[3:0] = sum5[3:0];
          ovf = sum5[4];
        end else if (byte0_i == `OP_ADC_IND) begin
          sum5 = {1'b0, ea_ff[3:0]} + {1'b0, mem_nibble_i}
                 + {4'h0, carry_ff};
          nxt_ea[3:0]  = sum5[3:0];
          nxt_carry    = sum5[4];
          nxt_adc_prev = 1'b1;
          nxt_adc_ovf  = sum5[4];
        end else if (byte0_i == `OP_ADD_BYTE) begin
          sum9 = {1'b0, ea_ff} + {1'b0, byte1_i};
          nxt_ea = sum9[7:0];
          ovf = sum9[8];
        end else if (src_op) begin
          sum9 = {1'b0, ea_ff} + {1'b0, pair_rd_data_i};
          nxt_ea = sum9[7:0];
          ovf = sum9[8];
        end else if (dst_op) begin
          // accumulator is the source here and stays as it is
          sum9 = {1'b0, ea_ff} + {1'b0, pair_rd_data_i};
          pair_we_o      = 1'b1;
          pair_wr_data_o = sum9[7:0];
          ovf = sum9[8];
        end
        // carry untouched by add-and-skip forms
        if (ovf)
          nxt_skip_pend = 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registers

  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      ea_ff        <= 8'h00;
      carry_ff     <= 1'b0;
      skip_pend_ff <= 1'b0;
      adc_ovf_ff   <= 1'b0;
      adc_prev_ff  <= 1'b0;
      cnt_ff       <= 2'h0;
      skip_o       <= 1'b0;
      done_o       <= 1'b0;
    end else begin
      ea_ff        <= nxt_ea;
      carry_ff     <= nxt_carry;
      skip_pend_ff <= nxt_skip_pend;
      adc_ovf_ff   <= nxt_adc_ovf;
      adc_prev_ff  <= nxt_adc_prev;
      cnt_ff       <= nxt_cnt;
      skip_o       <= nxt_skip;
      done_o       <= nxt_done;
    end
  end

endmodule // add_skip_overflow_exec

/* File: verification/add_skip_chk_sva.sv */
`timescale 1ns/1ps
module add_skip_chk (
  input logic       mclk_i,
  input logic       reset_n_i,
  input logic       instr_valid_i,
  input logic [7:0] byte0_i,
  input logic [7:0] byte1_i,
  input logic [3:0] mem_nibble_i,
  input logic       busy_o,
  input logic [3:0] work_nibble_o,
  input logic [7:0] extended_accumulator_o,
  input logic       carry_o,
  input logic       skip_o,
  input logic       done_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  wire go = instr_valid_i & ~busy_o;
  sequence two_cyc; busy_o ##1 !busy_o; endsequence
  AST_DONE: assert property (go |=> done_o) else $error("done");
  AST_ONE: assert property (go && byte0_i[7:4] == 4'ha |=> !busy_o)
    else $error("one");
  AST_TWO: assert property (go && byte0_i == 8'hc9 |=> two_cyc)
    else $error("two");
  AST_REF: assert property (busy_o |=> !done_o) else $error("ref");
  AST_CRY: assert property (
    go && byte0_i != 8'h3e |=> $stable(carry_o)) else $error("cry");
  AST_IND: assert property (go && byte0_i == 8'h3f |=> skip_o ||
    work_nibble_o == $past(work_nibble_o) + $past(mem_nibble_i))
    else $error("ind");
  AST_ADC: assert property (go && byte0_i == 8'h3e |=> skip_o ||
    {carry_o, work_nibble_o} == $past(work_nibble_o) + $past(mem_nibble_i)
    + $past(carry_o)) else $error("adc");
  AST_EA: assert property (
    go && byte0_i == 8'hdc && byte1_i[3] == 1'b0
    |=> $stable(extended_accumulator_o)) else $error("ea");
endmodule // add_skip_chk
bind add_skip_overflow_exec add_skip_chk chk (.*);

/* File: verification/add_skip_overflow_exec_tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module add_skip_overflow_exec_tb_top;
  logic       mclk_i = 0, reset_n_i = 0, instr_valid_i = 0;
  logic [7:0] byte0_i = 0, byte1_i = 0, pair_rd_data_i = 0, ea = 0;
  logic [3:0] mem_nibble_i = 0;
  wire        busy_o, pair_we_o, carry_o, skip_o, done_o;
  wire  [1:0] pair_sel_o;
  wire  [7:0] pair_wr_data_o, extended_accumulator_o;
  wire  [3:0] work_nibble_o;
  integer     errors = 0, n_tests = 0, seed = 34, i, s;
  logic       c = 0, sk = 0, ao = 0, aft = 0, sq, ns, nib;
  logic [7:0] op [4] = '{8'hc9, 8'h3f, 8'h3e, 8'hdc};
  always #2.5 mclk_i = ~mclk_i;
  add_skip_overflow_exec DUT (.*);
  ////////////////////////////////////////////////////////////////////////
  task iss(input [7:0] b0, b1, input [3:0] m, input [7:0] p);
    nib = b0[7:4] == 4'ha;
    sq = sk | (ao & nib);
    ns = 0;
    {byte0_i, byte1_i, mem_nibble_i, pair_rd_data_i} = {b0, b1, m, p};
    instr_valid_i = 1;
    #1;
    s = nib ? ea[3:0] + b0[3:0] : ea[3:0] + m + (b0[0] ? 0 : c);
    if (!sq & (nib | b0[7:1] == 7'h1f)) begin
      ea[3:0] = s[3:0];
      ns = s[4] & !(nib & aft) & b0 != 8'h3e;
      if (b0 == 8'h3e) c = s[4];
    end
    if (!sq & b0 == 8'hc9) begin
      s = ea + b1;
      ea = s[7:0];
      ns = s[8];
    end
    if (b0 == 8'hdc) `CHK(pair_sel_o, b1[2:1])
    if (sq | b0 != 8'hdc | b1[3]) `CHK(pair_we_o, 1'b0)
    if (!sq & b0 == 8'hdc) begin
      s = ea + p;
      ns = s[8];
      if (b1[3]) ea = s[7:0];
      else `CHK({pair_we_o, pair_wr_data_o}, {1'b1, s[7:0]})
    end
    ao = !sq & b0 == 8'h3e & s[4];
    aft = !sq & b0 == 8'h3e;
    sk = ns;
    @(negedge mclk_i);
    `CHK({done_o, skip_o, carry_o, extended_accumulator_o}, {1'b1, sq, c, ea})
    if (b0 == 8'hc9 | b0 == 8'hdc) begin
      @(negedge mclk_i);
      `CHK(done_o, 1'b0)
    end
  endtask
  task summarize;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    errors++;
    summarize;
  end
  initial begin
    repeat (12) @(negedge mclk_i);
    reset_n_i = 1;
    iss(8'ha8, 0, 0, 0);
    iss(8'ha6, 0, 0, 0);
    iss(8'h3e, 0, 9, 0);
    iss(8'haa, 0, 0, 0);
    iss(8'h3e, 0, 4, 0);
    iss(8'haa, 0, 0, 0);
    iss(8'haf, 0, 0, 0);
    iss(8'hdc, 8'h9a, 0, 8'hff);
    iss(8'hc9, 8'hff, 0, 0);
    iss(8'hdc, 8'h92, 0, 8'hf0);
    $display("directed done");
    for (i = 0; i < 400; i++) begin
      s = $random(seed);
      iss(s[2] ? {4'ha, s[11:8]} : op[s[1:0]], {4'h9, s[14:12], 1'b0},
          s[19:16], s[27:20]);
    end
    $display("random done");
    summarize;
  end
endmodule // add_skip_overflow_exec_tb_top
